// ===== design/vlc_pkg.sv
// Constants, field layouts and shared decode functions for the video layer
// channel control and interrupt mask register bank.
// Assumes a single 250 MHz clock and a plain strobe-based register port.
//
// How it works
// - Enable write with bit 0 set turns the channel on; zero does nothing.
// - Enable write with bit 1 set schedules attributes for next frame start.
// - Enable write with bit 2 set queues the head descriptor.
// - Queue request clears itself once the head is added to the list.
// - Disable write with bit 0 set stops the channel after this frame.
// - Disable write with bit 8 set resets the layer at once.
// - Status bit 0 reads one while the channel is on.
// - Status bit 1 reads one while an attribute update waits.
// - Status bit 2 reads one while a head queue request waits.
// - Interrupt enable write sets mask bits where ones are written.
// - Interrupt disable write clears mask bits where ones are written.
// - Mask view returns the current mask in the same layout.
// - Sources sit in five-bit groups at bits 2, 10 and 18.
// - Group at 10 is U or UV stream, group at 18 is V stream.
// - Event flags are sticky and clear when the interrupt status register is read.
package vlc_pkg;

   // ***************************************************
   // Register map (byte addresses)
   // ***************************************************
   localparam int unsigned DATA_W       = 32;
   localparam logic [31:0] OFS_CHAN_EN  = 32'hf8038280;
   localparam logic [31:0] OFS_CHAN_DIS = 32'hf8038284;
   localparam logic [31:0] OFS_CHAN_ST  = 32'hf8038288;
   localparam logic [31:0] OFS_IRQ_SET  = 32'hf803828c;
   localparam logic [31:0] OFS_IRQ_CLR  = 32'hf8038290;
   localparam logic [31:0] OFS_IRQ_MASK = 32'hf8038294;
   localparam logic [31:0] OFS_IRQ_STAT = 32'hf8038298;

   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int unsigned BIT_TURN_ON   = 0;
   localparam int unsigned BIT_ATTR_UPD  = 1;
   localparam int unsigned BIT_QUEUE     = 2;
   localparam int unsigned BIT_STOP      = 0;
   localparam int unsigned BIT_ABORT     = 8;
   localparam int unsigned GROUPS        = 3;
   localparam int unsigned GROUP_W       = 5;
   localparam int unsigned NSRC          = 15;
   localparam int          GROUP_BASE [GROUPS] = '{2, 10, 18};

   // ***************************************************
   // Reset values and channel states
   // ***************************************************
   localparam logic [31:0] WORD_ZERO = 32'h0;

   typedef enum logic [1:0] {CH_OFF, CH_RUN, CH_STOPPING} vlc_chan_state_type;

   // Register word to packed source vector, main/U/V groups in order
   function automatic logic [NSRC-1:0] word_to_src(input logic [31:0] w);
      logic [NSRC-1:0] s;
      s = '0;
      for (int g = 0; g < GROUPS; g++)
      begin
         for (int b = 0; b < GROUP_W; b++)
         begin
            s[g*GROUP_W+b] = w[GROUP_BASE[g]+b];
         end
      end
      return s;
   endfunction : word_to_src

   // Packed source vector back to register layout, gaps read zero
   function automatic logic [31:0] src_to_word(input logic [NSRC-1:0] s);
      logic [31:0] w;
      w = WORD_ZERO;
      for (int g = 0; g < GROUPS; g++)
      begin
         for (int b = 0; b < GROUP_W; b++)
         begin
            w[GROUP_BASE[g]+b] = s[g*GROUP_W+b];
         end
      end
      return w;
   endfunction : src_to_word

endpackage : vlc_pkg

// ===== design/vlc_event_flags.sv
// Sticky event flags with a clear-all strobe.
// Assumes events and clear come from logic on the same clock.
`timescale 1ns/1ns
module vlc_event_flags #(
   parameter int unsigned W = 15
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] set_bits,
   input  wire logic         clear_all,
   output logic      [W-1:0] flags
);

   // ***************************************************
   // State
   // ***************************************************
   typedef struct packed {
      logic [W-1:0] flags;
   } vlc_flag_state_type;

   vlc_flag_state_type st_q;
   vlc_flag_state_type st_d;

   if (W < 1)
   begin : g_bad_w
      $error("vlc_event_flags: W must be at least one");
   end

   // Set beats clear so an event in the read cycle is kept
   always_comb
   begin
      st_d       = st_q;
      st_d.flags = set_bits | (st_q.flags & ~{W{clear_all}});
   end

   // Frozen while clock enable is low
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         st_q <= '0;
      else if (ce)
         st_q <= st_d;
   end

   assign flags = st_q.flags;

endmodule : vlc_event_flags

// ===== design/vlc_mask_bits.sv
// Mask register written through separate set and clear strobes.
// Assumes set and clear never arrive together (one write per cycle).
`timescale 1ns/1ns
module vlc_mask_bits #(
   parameter int unsigned W = 15
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         ce,
   input  wire logic [W-1:0] set_bits,
   input  wire logic [W-1:0] clr_bits,
   output logic      [W-1:0] mask
);

   // ***************************************************
   // State
   // ***************************************************
   typedef struct packed {
      logic [W-1:0] mask;
   } vlc_mask_state_type;

   vlc_mask_state_type st_q;
   vlc_mask_state_type st_d;

   if (W < 1)
   begin : g_bad_w
      $error("vlc_mask_bits: W must be at least one");
   end

   // Zeros written leave bits alone
   always_comb
   begin
      st_d      = st_q;
      st_d.mask = (st_q.mask | set_bits) & ~clr_bits;
   end

   // All sources disabled after reset
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         st_q <= '0;
      else if (ce)
         st_q <= st_d;
   end

   assign mask = st_q.mask;

endmodule : vlc_mask_bits

// ===== design/vlc_layer_ctrl.sv
// Channel control, status and interrupt mask registers of the video layer.
// Assumes the layer engine on the same clock gives one-cycle pulses for
// frame start, frame end, head accepted and each interrupt source.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
module vlc_layer_ctrl #(
   parameter int unsigned SRC_W = vlc_pkg::NSRC
) (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              ce,
   input  wire logic [31:0]       addr,
   input  wire logic [31:0]       wdata,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic      [31:0]       rdata,
   input  wire logic              frame_start,
   input  wire logic              frame_end,
   input  wire logic              head_added,
   input  wire logic [SRC_W-1:0]  src_events,
   output logic                   channel_on_flag,
   output logic                   attr_update_pending,
   output logic                   queue_head_pending,
   output logic                   attr_apply,
   output logic                   layer_abort,
   output logic                   irq
);

   // ***************************************************
   // Elaboration check
   // ***************************************************
   if (SRC_W != vlc_pkg::GROUPS * vlc_pkg::GROUP_W)
   begin : g_bad_src
      $error("vlc_layer_ctrl: SRC_W must match the register layout");
   end

   // ***************************************************
   // State
   // ***************************************************
   typedef struct packed {
      vlc_pkg::vlc_chan_state_type chan;
      logic                        on;
      logic                        upd_pend;
      logic                        q_pend;
      logic                        apply;
      logic                        abort;
      logic                        irq;
      logic [31:0]                 rdata;
   } vlc_top_state_type;

   vlc_top_state_type st_q;
   vlc_top_state_type st_d;

   logic              en_wr;
   logic              dis_wr;
   logic              set_wr;
   logic              clr_wr;
   logic              st_rd;
   logic              mask_rd;
   logic              stat_rd;
   logic [SRC_W-1:0]  mask_bits;
   logic [SRC_W-1:0]  stat_bits;
   logic [SRC_W-1:0]  wr_src;
   logic              turn_on;
   logic              stop_req;
   logic              abort_req;
   logic              upd_req;
   logic              queue_req;

   // ***************************************************
   // Register decode
   // ***************************************************
   // Full address compare; unmapped reads return zero
   assign en_wr   = wr_en && (addr == vlc_pkg::OFS_CHAN_EN);
   assign dis_wr  = wr_en && (addr == vlc_pkg::OFS_CHAN_DIS);
   assign set_wr  = wr_en && (addr == vlc_pkg::OFS_IRQ_SET);
   assign clr_wr  = wr_en && (addr == vlc_pkg::OFS_IRQ_CLR);
   assign st_rd   = rd_en && (addr == vlc_pkg::OFS_CHAN_ST);
   assign mask_rd = rd_en && (addr == vlc_pkg::OFS_IRQ_MASK);
   assign stat_rd = rd_en && (addr == vlc_pkg::OFS_IRQ_STAT);

   // Command bits; a zero in any of them has no effect
   assign turn_on   = en_wr && wdata[vlc_pkg::BIT_TURN_ON];
   assign upd_req   = en_wr && wdata[vlc_pkg::BIT_ATTR_UPD];
   assign queue_req = en_wr && wdata[vlc_pkg::BIT_QUEUE];
   assign stop_req  = dis_wr && wdata[vlc_pkg::BIT_STOP];
   assign abort_req = dis_wr && wdata[vlc_pkg::BIT_ABORT];

   // Write data folded into the fifteen source positions
   assign wr_src = vlc_pkg::word_to_src(wdata);

   // ***************************************************
   // Interrupt mask and event flags
   // ***************************************************
   vlc_mask_bits #(
      .W (SRC_W)
   ) u_mask (
      .clk      (clk),
      .reset_n  (reset_n),
      .ce       (ce),
      .set_bits (set_wr ? wr_src : '0),
      .clr_bits (clr_wr ? wr_src : '0),
      .mask     (mask_bits)
   );

   vlc_event_flags #(
      .W (SRC_W)
   ) u_flags (
      .clk       (clk),
      .reset_n   (reset_n),
      .ce        (ce),
      .set_bits  (src_events),
      .clear_all (stat_rd),
      .flags     (stat_bits)
   );

   // ***************************************************
   // Next state
   // ***************************************************
   // Abort outranks all; a re-enable while stopping cancels the stop
   always_comb
   begin
      st_d       = st_q;
      st_d.apply = 1'b0;
      st_d.abort = 1'b0;

      unique case (st_q.chan)
         vlc_pkg::CH_OFF:
         begin
            if (turn_on)
               st_d.chan = vlc_pkg::CH_RUN;
         end
         vlc_pkg::CH_RUN:
         begin
            if (stop_req)
               st_d.chan = vlc_pkg::CH_STOPPING;
         end
         vlc_pkg::CH_STOPPING:
         begin
            if (turn_on)
               st_d.chan = vlc_pkg::CH_RUN;
            else if (frame_end)
               st_d.chan = vlc_pkg::CH_OFF;
         end
         // Unused fourth code falls back to off
         default:
         begin
            st_d.chan = vlc_pkg::CH_OFF;
         end
      endcase

      // Update waits for a frame start; a new request in that cycle stays
      st_d.apply    = st_q.upd_pend && frame_start;
      st_d.upd_pend = upd_req || (st_q.upd_pend && !frame_start);

      // Head request drops when the engine accepts it; set wins
      st_d.q_pend = queue_req || (st_q.q_pend && !head_added);

      // Immediate reset drops the frame and every pending request
      if (abort_req)
      begin
         st_d.chan     = vlc_pkg::CH_OFF;
         st_d.upd_pend = 1'b0;
         st_d.q_pend   = 1'b0;
         st_d.apply    = 1'b0;
         st_d.abort    = 1'b1;
      end

      // Registered copy, so the status output comes straight from a flop
      st_d.on = (st_d.chan != vlc_pkg::CH_OFF);

      // Level interrupt from flags gated by mask
      st_d.irq = |(stat_bits & mask_bits);

      // Read data stand only in the cycle after the strobe
      st_d.rdata = vlc_pkg::WORD_ZERO;
      if (st_rd)
      begin
         st_d.rdata[vlc_pkg::BIT_TURN_ON]  = (st_q.chan != vlc_pkg::CH_OFF);
         st_d.rdata[vlc_pkg::BIT_ATTR_UPD] = st_q.upd_pend;
         st_d.rdata[vlc_pkg::BIT_QUEUE]    = st_q.q_pend;
      end
      else if (mask_rd)
         st_d.rdata = vlc_pkg::src_to_word(mask_bits);
      else if (stat_rd)
         st_d.rdata = vlc_pkg::src_to_word(stat_bits);
   end

   // ***************************************************
   // Registers
   // ***************************************************
   // Clock enable freezes everything, including pulses
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_q.chan     <= vlc_pkg::CH_OFF;
         st_q.on       <= 1'b0;
         st_q.upd_pend <= 1'b0;
         st_q.q_pend   <= 1'b0;
         st_q.apply    <= 1'b0;
         st_q.abort    <= 1'b0;
         st_q.irq      <= 1'b0;
         st_q.rdata    <= vlc_pkg::WORD_ZERO;
      end
      else if (ce)
         st_q <= st_d;
   end

   // ***************************************************
   // Outputs, all straight from flip-flops
   // ***************************************************
   assign rdata               = st_q.rdata;
   assign channel_on_flag     = st_q.on;
   assign attr_update_pending = st_q.upd_pend;
   assign queue_head_pending  = st_q.q_pend;
   assign attr_apply          = st_q.apply;
   assign layer_abort         = st_q.abort;
   assign irq                 = st_q.irq;

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Stop request seen while running
   sequence seq_stop_req;
      ce && stop_req && !abort_req && (st_q.chan == vlc_pkg::CH_RUN);
   endsequence

   // Frame finishes while stopping and nothing re-enables
   sequence seq_frame_done;
      ce && (st_q.chan == vlc_pkg::CH_STOPPING) && frame_end && !turn_on && !abort_req;
   endsequence

   AST_TURN_ON: assert property (ce && turn_on |=> channel_on_flag)
      else $error("channel not on after enable write");

   AST_ZERO_NO_EFFECT: assert property (
      ce && en_wr && !turn_on && !channel_on_flag |=> !channel_on_flag)
      else $error("enable write of zero changed the channel");

   AST_UPD_SET: assert property (ce && upd_req |=> attr_update_pending)
      else $error("attribute update not pending after request");

   AST_UPD_APPLY: assert property (
      ce && attr_update_pending && frame_start && !upd_req && !abort_req
      |=> attr_apply && !attr_update_pending)
      else $error("attribute update not applied at frame start");

   AST_QUEUE_SET: assert property (ce && queue_req |=> queue_head_pending)
      else $error("head request not pending after write");

   AST_QUEUE_CLR: assert property (
      ce && queue_head_pending && head_added && !queue_req
      |=> !queue_head_pending)
      else $error("head request not cleared after acceptance");

   AST_STOP_FRAME: assert property (
      seq_stop_req ##1 (!ce || !frame_end) |-> channel_on_flag)
      else $error("channel stopped before frame end");

   AST_STOP_DONE: assert property (seq_frame_done |=> !channel_on_flag)
      else $error("channel still on after frame end");

   AST_ABORT: assert property (
      ce && abort_req |=> !channel_on_flag && layer_abort
         && !attr_update_pending && !queue_head_pending)
      else $error("immediate reset incomplete");

   AST_STATE_READ: assert property (
      ce && st_rd |=> rdata == {29'h0, $past(queue_head_pending),
         $past(attr_update_pending), $past(channel_on_flag)})
      else $error("channel state read mismatch");

   AST_MASK_SET: assert property (
      ce && set_wr |=> (mask_bits & $past(wr_src)) == $past(wr_src)
         && (mask_bits | $past(wr_src)) == ($past(mask_bits) | $past(wr_src)))
      else $error("mask set write wrong");

   AST_MASK_CLR: assert property (
      ce && clr_wr |=> mask_bits == ($past(mask_bits) & ~$past(wr_src)))
      else $error("mask clear write wrong");

   AST_MASK_READ: assert property (
      ce && mask_rd |=> rdata == vlc_pkg::src_to_word($past(mask_bits)))
      else $error("mask view read mismatch");

   AST_LAYOUT: assert property (
      ce && mask_rd |=> (rdata & 32'hff838383) == 32'h0)
      else $error("mask read has bits outside source groups");

   AST_GROUP_UV: assert property (
      ce && stat_rd |=> rdata[14:10] == $past(stat_bits[9:5])
         && rdata[22:18] == $past(stat_bits[14:10]))
      else $error("chroma groups misplaced");

   AST_STAT_CLR: assert property (
      ce && stat_rd |=> stat_bits == $past(src_events))
      else $error("status not cleared by read");

   AST_IRQ: assert property (ce |=> irq == $past(|(stat_bits & mask_bits)))
      else $error("interrupt output wrong");

   // Update still waiting: no frame start and no reset yet
   sequence seq_upd_wait;
      ce && attr_update_pending && !frame_start && !abort_req;
   endsequence

   // Stop requested, frame not yet over
   sequence seq_stopping;
      ce && (st_q.chan == vlc_pkg::CH_STOPPING) && !frame_end && !abort_req;
   endsequence

   AST_ON_MATCH: assert property (channel_on_flag == (st_q.chan != vlc_pkg::CH_OFF))
      else $error("status copy of channel state wrong");

   AST_APPLY_PULSE: assert property (ce && attr_apply && !frame_start |=> !attr_apply)
      else $error("apply pulse longer than one cycle");

   AST_ABORT_PULSE: assert property (ce && layer_abort && !abort_req |=> !layer_abort)
      else $error("reset pulse longer than one cycle");

   AST_UPD_HOLD: assert property (seq_upd_wait |=> attr_update_pending)
      else $error("attribute update dropped early");

   AST_QUEUE_HOLD: assert property (
      ce && queue_head_pending && !head_added && !abort_req |=> queue_head_pending)
      else $error("head request dropped early");

   AST_STOP_HOLD: assert property (seq_stopping |=> channel_on_flag)
      else $error("channel stopped inside the frame");

   AST_FLAG_SET: assert property (
      ce |=> (stat_bits & $past(src_events)) == $past(src_events))
      else $error("event did not set its flag");

   AST_FLAG_KEEP: assert property (
      ce && !stat_rd |=> (stat_bits & $past(stat_bits)) == $past(stat_bits))
      else $error("flag lost without a status read");

   AST_MASK_HOLD: assert property (
      ce && !set_wr && !clr_wr |=> mask_bits == $past(mask_bits))
      else $error("mask changed without a write");

   // Frozen clock enable holds every register, pulses included
   AST_CE_FREEZE: assert property (
      !ce |=> st_q == $past(st_q) && stat_bits == $past(stat_bits) && mask_bits == $past(mask_bits))
      else $error("state moved while clock enable low");

endmodule : vlc_layer_ctrl

// ===== dv/tb_top.sv
// Self-checking bench for the video layer channel control register bank.
// Drives the register port and the layer engine pulses directly; no partner.
`timescale 1ns/1ns
// Compare two values, count it, report a mismatch at once
`define CHK(nm, ex, got) \
   begin \
      num_checks++; \
      if ((got) !== (ex)) \
      begin \
         bad_count++; \
         $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
      end \
   end
module tb_top;
   // ***************************************************
   // Signals and counters
   // ***************************************************
   logic                      clk         = 1'b0;
   logic                      reset_n     = 1'b0;
   logic                      ce          = 1'b1;
   logic [31:0]               addr        = 32'h0;
   logic [31:0]               wdata       = 32'h0;
   logic                      wr_en       = 1'b0;
   logic                      rd_en       = 1'b0;
   logic [31:0]               rdata;
   logic                      frame_start = 1'b0;
   logic                      frame_end   = 1'b0;
   logic                      head_added  = 1'b0;
   logic [vlc_pkg::NSRC-1:0]  src_events  = '0;
   logic                      channel_on_flag;
   logic                      attr_update_pending;
   logic                      queue_head_pending;
   logic                      attr_apply;
   logic                      layer_abort;
   logic                      irq;
   int                        bad_count;
   int                        num_checks;
   int                        cycles;
   logic [31:0]               rd_val;
   // ***************************************************
   // Clock, reset and watchdog
   // ***************************************************
   initial
      forever #2 clk = ~clk;
   // Ceiling well above the few hundred cycles the tests need
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         bad_count++;
         end_of_test();
      end
   end
   // Design under test; clock enable driven so that freezing is exercised
   vlc_layer_ctrl vlc_layer_ctrl_inst (
      .clk                 (clk),
      .reset_n             (reset_n),
      .ce                  (ce),
      .addr                (addr),
      .wdata               (wdata),
      .wr_en               (wr_en),
      .rd_en               (rd_en),
      .rdata               (rdata),
      .frame_start         (frame_start),
      .frame_end           (frame_end),
      .head_added          (head_added),
      .src_events          (src_events),
      .channel_on_flag     (channel_on_flag),
      .attr_update_pending (attr_update_pending),
      .queue_head_pending  (queue_head_pending),
      .attr_apply          (attr_apply),
      .layer_abort         (layer_abort),
      .irq                 (irq)
   );
   // ***************************************************
   // Bus and pulse tasks
   // ***************************************************
   // One-cycle write strobe; returns just after the taking edge
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rdata;
   endtask : rd
   task automatic pulse(input logic fs, input logic fe, input logic ha, input logic [vlc_pkg::NSRC-1:0] ev);
      @(posedge clk);
      frame_start <= fs;
      frame_end   <= fe;
      head_added  <= ha;
      src_events  <= ev;
      @(posedge clk);
      frame_start <= 1'b0;
      frame_end   <= 1'b0;
      head_added  <= 1'b0;
      src_events  <= '0;
      #1;
   endtask : pulse
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   // ***************************************************
   // Test sequence
   // ***************************************************
   initial
   begin
      logic [31:0] bit_w;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      // Reset values, unmapped and read-only places
      rd(vlc_pkg::OFS_CHAN_ST, rd_val);
      `CHK("state after reset", 32'h0, rd_val)
      rd(vlc_pkg::OFS_IRQ_MASK, rd_val);
      `CHK("mask after reset", 32'h0, rd_val)
      rd(32'hf803829c, rd_val);
      `CHK("unmapped read", 32'h0, rd_val)
      wr(vlc_pkg::OFS_CHAN_ST, 32'h7);
      rd(vlc_pkg::OFS_CHAN_ST, rd_val);
      `CHK("state after write to read-only", 32'h0, rd_val)
      $display("test reset_map done");
      // Frozen enable write ignored, then enable, ignored events, stop at frame end
      @(posedge clk) ce <= 1'b0;
      wr(vlc_pkg::OFS_CHAN_EN, 32'h1);
      `CHK("enable while frozen", 1'b0, channel_on_flag)
      @(posedge clk) ce <= 1'b1;
      wr(vlc_pkg::OFS_CHAN_EN, 32'h0);
      `CHK("on after zero write", 1'b0, channel_on_flag)
      wr(vlc_pkg::OFS_CHAN_DIS, 32'h1);
      `CHK("stop while off", 1'b0, channel_on_flag)
      wr(vlc_pkg::OFS_CHAN_EN, 32'h1);
      `CHK("on after enable", 1'b1, channel_on_flag)
      rd(vlc_pkg::OFS_CHAN_ST, rd_val);
      `CHK("state running", 32'h1, rd_val)
      pulse(1'b0, 1'b1, 1'b0, '0);
      `CHK("frame end while running", 1'b1, channel_on_flag)
      wr(vlc_pkg::OFS_CHAN_DIS, 32'h1);
      rd(vlc_pkg::OFS_CHAN_ST, rd_val);
      `CHK("state stopping", 32'h1, rd_val)
      pulse(1'b0, 1'b1, 1'b0, '0);
      `CHK("off after frame end", 1'b0, channel_on_flag)
      rd(vlc_pkg::OFS_CHAN_ST, rd_val);
      `CHK("state stopped", 32'h0, rd_val)
      $display("test channel done");
      // Attribute update waits for frame start
      wr(vlc_pkg::OFS_CHAN_EN, 32'h2);
      rd(vlc_pkg::OFS_CHAN_ST, rd_val);
      `CHK("state update waiting", 32'h2, rd_val)
      pulse(1'b1, 1'b0, 1'b0, '0);
      `CHK("apply pulse", 1'b1, attr_apply)
      `CHK("update pending cleared", 1'b0, attr_update_pending)
      tick();
      `CHK("apply pulse ends", 1'b0, attr_apply)
      // Queue request clears itself when the head is taken
      wr(vlc_pkg::OFS_CHAN_EN, 32'h4);
      rd(vlc_pkg::OFS_CHAN_ST, rd_val);
      `CHK("state queue waiting", 32'h4, rd_val)
      pulse(1'b0, 1'b0, 1'b1, '0);
      `CHK("queue pending cleared", 1'b0, queue_head_pending)
      // Immediate reset drops everything
      wr(vlc_pkg::OFS_CHAN_EN, 32'h7);
      rd(vlc_pkg::OFS_CHAN_ST, rd_val);
      `CHK("state all set", 32'h7, rd_val)
      wr(vlc_pkg::OFS_CHAN_DIS, 32'h100);
      `CHK("abort pulse", 1'b1, layer_abort)
      tick();
      `CHK("abort pulse ends", 1'b0, layer_abort)
      rd(vlc_pkg::OFS_CHAN_ST, rd_val);
      `CHK("state after abort", 32'h0, rd_val)
      $display("test update_queue_abort done");
      // Mask set and clear, zeros leave bits alone
      wr(vlc_pkg::OFS_IRQ_SET, 32'h007c7c7c);
      wr(vlc_pkg::OFS_IRQ_CLR, 32'h0);
      rd(vlc_pkg::OFS_IRQ_MASK, rd_val);
      `CHK("mask full", 32'h007c7c7c, rd_val)
      wr(vlc_pkg::OFS_IRQ_SET, 32'h0);
      wr(vlc_pkg::OFS_IRQ_CLR, 32'h007c7c7c);
      rd(vlc_pkg::OFS_IRQ_MASK, rd_val);
      `CHK("mask empty", 32'h0, rd_val)
      // Each source: enabled raises irq, masked only sets its flag
      for (int i = 0; i < 15; i++)
      begin
         bit_w = 32'h1 << (2 + 8 * (i / 5) + i % 5);
         wr(vlc_pkg::OFS_IRQ_SET, bit_w);
         rd(vlc_pkg::OFS_IRQ_MASK, rd_val);
         `CHK("mask one source", bit_w, rd_val)
         pulse(1'b0, 1'b0, 1'b0, 15'h1 << i);
         tick();
         `CHK("irq enabled source", 1'b1, irq)
         rd(vlc_pkg::OFS_IRQ_STAT, rd_val);
         `CHK("status one source", bit_w, rd_val)
         tick();
         `CHK("irq after status read", 1'b0, irq)
         rd(vlc_pkg::OFS_IRQ_STAT, rd_val);
         `CHK("status cleared by read", 32'h0, rd_val)
         wr(vlc_pkg::OFS_IRQ_CLR, bit_w);
         rd(vlc_pkg::OFS_IRQ_MASK, rd_val);
         `CHK("mask after clear", 32'h0, rd_val)
         pulse(1'b0, 1'b0, 1'b0, 15'h1 << i);
         tick();
         `CHK("irq masked source", 1'b0, irq)
         rd(vlc_pkg::OFS_IRQ_STAT, rd_val);
         `CHK("status masked source", bit_w, rd_val)
      end
      $display("test interrupts done");
      end_of_test();
   end
endmodule : tb_top
